// ### verilog/wpm_regs.svh
`ifndef WPM_REGS_SVH
`define WPM_REGS_SVH

// Register byte offsets
`define WPM_CTRL_ADDR     12'h000
`define WPM_WAVE_ADDR     12'h004
`define WPM_FREQ_ADDR     12'h008
`define WPM_PHASE_ADDR    12'h00C
`define WPM_STATUS_ADDR   12'h010
`define WPM_ERRCLR_ADDR   12'h014

// Control field positions
`define WPM_CTRL_SQ_LSB     0
`define WPM_CTRL_AUX_LSB    2
`define WPM_CTRL_FLT_LSB    4
`define WPM_CTRL_WAVEFORM_FREQ_LIMIT_ENABLE_BIT  6
`define WPM_CTRL_REAR_LSB   7
`define WPM_CTRL_FSK_BIT    9
`define WPM_CTRL_HOP_BIT    10
`define WPM_CTRL_SWCMD_BIT  11
`define WPM_CTRL_SWEDIT_BIT 12

// Reset values: all options automatic, frequency stop off
`define WPM_CTRL_RESET    32'h0000_0000
`define WPM_FREQ_RESET    32'h0000_03E8

// Frequency thresholds in Hz
`define WPM_CHANGEOVER_HZ 32'h0000_7530
`define WPM_WAVEFORM_FREQ_LIMIT_ENABLE_HZ      32'h0001_86A0

// Sample clock divisor where sampling jitter appears
`define WPM_JITTER_DIV    11'h400

// Phase accumulator width and indicator flash half period
`define WPM_PHASE_W       32
`define WPM_FLASH_CYCLES  24'h4C_4B40

`endif

// ### verilog/wpm_pkg.sv
`default_nettype none
package wpm_pkg;
    typedef enum logic [1:0] {
        WPM_SEL_AUTO = 2'b00,
        WPM_SEL_LOW  = 2'b01,
        WPM_SEL_HIGH = 2'b10
    } wpm_gen_t;

    typedef enum logic [1:0] {
        WPM_FLT_AUTO = 2'b00,
        WPM_FLT_ON   = 2'b01,
        WPM_FLT_OFF  = 2'b10
    } wpm_flt_t;

    typedef enum logic [1:0] {
        WPM_REAR_AUTO  = 2'b00,
        WPM_REAR_SWEEP = 2'b01,
        WPM_REAR_TRIG  = 2'b10
    } wpm_rear_t;

    typedef enum logic [2:0] {
        WPM_W_SINE  = 3'b000,
        WPM_W_TRI   = 3'b001,
        WPM_W_SQ    = 3'b010,
        WPM_W_PULSE = 3'b011,
        WPM_W_RAMP  = 3'b100,
        WPM_W_STAIR = 3'b101,
        WPM_W_ARB   = 3'b110,
        WPM_W_NOISE = 3'b111
    } wpm_wave_t;

    // Registered selects toward the analog path
    typedef struct packed {
        logic square_comparator;
        logic aux_comparator;
        logic elliptic_filter_on;
        logic rc_filter_on;
    } wpm_path_t;
endpackage
`default_nettype wire

// ### verilog/wpm_mode_select.sv
`default_nettype none
`include "wpm_regs.svh"
module wpm_mode_select #(
    parameter int unsigned FLASH_CYCLES = 5000000
) (
    // System
    input  wire logic                clk_sys,
    input  wire logic                rst,
    input  wire logic                clk_en,
    // APB slave
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [11:0]         paddr,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    // Generator status inputs
    input  wire logic                comparator_in,
    input  wire logic                trig_gen_in,
    input  wire logic                trig_gen_synced,
    input  wire logic                sweep_marker_in,
    input  wire logic                hop_marker_in,
    input  wire logic [31:0]         symmetry_count,
    // Analog path
    output wpm_pkg::wpm_path_t       path_sel,
    output logic                     aux_out,
    output logic                     square_out,
    output logic                     rear_marker_trigger_output,
    output logic                     sweep_lamp,
    output logic [31:0]              mem_address
);
    // Settings registers
    logic [31:0] ctrl_reg;
    logic [2:0]  wave_reg;
    logic [31:0] freq_reg;
    logic [31:0] phase_reg;
    logic        err_reg;
    logic        sweep_on_reg;
    logic        held_high_reg;
    logic [31:0] acc_reg;
    logic [23:0] flash_cnt_reg;
    logic        flash_reg;
    wpm_pkg::wpm_path_t path_next;

    // Decoded fields
    wire wpm_pkg::wpm_gen_t  square_source_select =
        wpm_pkg::wpm_gen_t'(ctrl_reg[`WPM_CTRL_SQ_LSB +: 2]);
    wire wpm_pkg::wpm_gen_t  aux_sel =
        wpm_pkg::wpm_gen_t'(ctrl_reg[`WPM_CTRL_AUX_LSB +: 2]);
    wire wpm_pkg::wpm_flt_t  flt_sel =
        wpm_pkg::wpm_flt_t'(ctrl_reg[`WPM_CTRL_FLT_LSB +: 2]);
    wire wpm_pkg::wpm_rear_t rear_output_function_select =
        wpm_pkg::wpm_rear_t'(ctrl_reg[`WPM_CTRL_REAR_LSB +: 2]);
    wire waveform_freq_limit_enable = ctrl_reg[`WPM_CTRL_WAVEFORM_FREQ_LIMIT_ENABLE_BIT];
    wire fsk_on                     = ctrl_reg[`WPM_CTRL_FSK_BIT];
    wire waveform_hop_mode          = ctrl_reg[`WPM_CTRL_HOP_BIT];
    wire sweep_edit                 = ctrl_reg[`WPM_CTRL_SWEDIT_BIT];

    // Waveform classes used by several decisions
    function automatic logic is_limited(input logic [2:0] w);
        is_limited = (w == wpm_pkg::WPM_W_TRI) || (w == wpm_pkg::WPM_W_RAMP) ||
                     (w == wpm_pkg::WPM_W_STAIR) || (w == wpm_pkg::WPM_W_ARB);
    endfunction
    function automatic logic is_sym(input logic [2:0] w);
        is_sym = (w == wpm_pkg::WPM_W_SINE) || (w == wpm_pkg::WPM_W_TRI) ||
                 (w == wpm_pkg::WPM_W_SQ) || (w == wpm_pkg::WPM_W_PULSE);
    endfunction
    function automatic logic is_sqp(input logic [2:0] w);
        is_sqp = (w == wpm_pkg::WPM_W_SQ) || (w == wpm_pkg::WPM_W_PULSE);
    endfunction

    // APB decode; zero wait state
    wire        wr_en    = psel && penable && pwrite;
    wire        hit_ctrl = paddr == `WPM_CTRL_ADDR;
    wire        hit_wave = paddr == `WPM_WAVE_ADDR;
    wire        hit_freq = paddr == `WPM_FREQ_ADDR;
    wire        hit_ph   = paddr == `WPM_PHASE_ADDR;
    wire        hit_st   = paddr == `WPM_STATUS_ADDR;
    wire        hit_ec   = paddr == `WPM_ERRCLR_ADDR;
    wire        mapped   = hit_ctrl | hit_wave | hit_freq | hit_ph | hit_st | hit_ec;
    wire        sweep_running = sweep_on_reg;
    wire        sweep_cmd = wr_en && hit_ctrl && pwdata[`WPM_CTRL_SWCMD_BIT];

    // Frequency stop checks on the requested value
    wire        freq_bad = wr_en && hit_freq && waveform_freq_limit_enable &&
                           is_limited(wave_reg) && (pwdata > `WPM_WAVEFORM_FREQ_LIMIT_ENABLE_HZ);
    wire        wave_bad = wr_en && hit_wave && waveform_freq_limit_enable &&
                           is_limited(pwdata[2:0]) && (freq_reg > `WPM_WAVEFORM_FREQ_LIMIT_ENABLE_HZ);

    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;

    // Read mux
    wire [31:0] status_word = {22'h0, flash_reg, sweep_on_reg, held_high_reg,
                               path_sel, aux_out, square_out, err_reg};
    assign prdata = hit_ctrl ? ctrl_reg :
                    hit_wave ? {29'h0, wave_reg} :
                    hit_freq ? freq_reg :
                    hit_ph   ? phase_reg :
                    hit_st   ? status_word : 32'h0000_0000;

    // Settings writes; a rejected value leaves the old one
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            ctrl_reg  <= `WPM_CTRL_RESET;
            wave_reg  <= 3'h0;
            freq_reg  <= `WPM_FREQ_RESET;
            phase_reg <= 32'h0000_0000;
        end
        else if (clk_en && wr_en)
        begin
            if (hit_ctrl)
                ctrl_reg <= pwdata & ~(32'h1 << `WPM_CTRL_SWCMD_BIT);
            if (hit_wave && !wave_bad)
                wave_reg <= pwdata[2:0];
            if (hit_freq && !freq_bad)
                freq_reg <= pwdata;
            if (hit_ph)
                phase_reg <= pwdata;
        end
    end

    // Sticky error: new error wins over a clear
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            err_reg <= 1'b0;
        else if (clk_en)
        begin
            if (freq_bad || wave_bad)
                err_reg <= 1'b1;
            else if (wr_en && hit_ec && pwdata[0])
                err_reg <= 1'b0;
        end
    end

    // Sweep toggle and the mode held across sweep/FSK
    wire above_change = freq_reg > `WPM_CHANGEOVER_HZ;
    wire hold_active  = sweep_on_reg || fsk_on;
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            sweep_on_reg  <= 1'b0;
            held_high_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            if (sweep_cmd)
                sweep_on_reg <= !sweep_on_reg;
            if (!hold_active)
                held_high_reg <= above_change;
        end
    end

    // Indicator flash timer for sweep editing
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            flash_cnt_reg <= 24'h00_0000;
            flash_reg     <= 1'b0;
        end
        else if (clk_en)
        begin
            if (flash_cnt_reg >= 24'(FLASH_CYCLES - 1))
            begin
                flash_cnt_reg <= 24'h00_0000;
                flash_reg     <= !flash_reg;
            end
            else
                flash_cnt_reg <= flash_cnt_reg + 24'h00_0001;
        end
    end
    assign sweep_lamp = sweep_edit ? flash_reg : sweep_on_reg;

    // Square source decision
    wire auto_high = hold_active ? held_high_reg : above_change;
    wire sq_comp   = (square_source_select == wpm_pkg::WPM_SEL_HIGH) ||
                     ((square_source_select == wpm_pkg::WPM_SEL_AUTO) && auto_high);
    // Aux source decision; forced low never uses the comparator
    wire aux_comp  = (aux_sel == wpm_pkg::WPM_SEL_HIGH) ||
                     ((aux_sel == wpm_pkg::WPM_SEL_AUTO) && is_sym(wave_reg) &&
                      above_change);
    // Filter decision
    wire flt_auto  = (wave_reg == wpm_pkg::WPM_W_SINE) ||
                     (wave_reg == wpm_pkg::WPM_W_TRI) ||
                     (is_sqp(wave_reg) && sq_comp);
    wire is_noise  = wave_reg == wpm_pkg::WPM_W_NOISE;
    wire flt_on    = !is_noise && ((flt_sel == wpm_pkg::WPM_FLT_ON) ||
                     ((flt_sel != wpm_pkg::WPM_FLT_OFF) && flt_auto));

    assign path_next.square_comparator  = sq_comp;
    assign path_next.aux_comparator     = aux_comp;
    assign path_next.elliptic_filter_on = flt_on;
    assign path_next.rc_filter_on       = is_noise;

    // Phase accumulator: address 0 is zero phase
    wire [31:0] aux_phase = acc_reg - phase_reg;
    assign mem_address = acc_reg;
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            acc_reg <= 32'h0000_0000;
        end
        else if (clk_en)
        begin
            acc_reg <= acc_reg + freq_reg;
        end
    end

    // Registered selects and digital squares, one sample clock of jitter
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            path_sel   <= '0;
            square_out <= 1'b0;
            aux_out    <= 1'b0;
        end
        else if (clk_en)
        begin
            path_sel   <= path_next;
            // Digital high phase starts at zero: rising edge on first address
            square_out <= path_next.square_comparator ? comparator_in :
                          (acc_reg < symmetry_count);
            aux_out    <= path_next.aux_comparator ? comparator_in :
                          (aux_phase < symmetry_count);
        end
    end

    // Rear output selection
    logic rear_mux;
    always_comb
    begin
        case (rear_output_function_select)
            wpm_pkg::WPM_REAR_TRIG:  rear_mux = trig_gen_in;
            wpm_pkg::WPM_REAR_SWEEP: rear_mux = waveform_hop_mode ? hop_marker_in
                                                : sweep_marker_in;
            default: rear_mux = sweep_running ? sweep_marker_in :
                                waveform_hop_mode ? hop_marker_in : trig_gen_in;
        endcase
    end
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            rear_marker_trigger_output <= 1'b0;
        else if (clk_en)
            rear_marker_trigger_output <= rear_mux;
    end

    // Assertions
    a_freq_rejected: assert property (@(posedge clk_sys) disable iff (rst)
        (clk_en && freq_bad) |=> (freq_reg == $past(freq_reg)))
        else $error("rejected frequency was stored");
    a_err_sets: assert property (@(posedge clk_sys) disable iff (rst)
        (clk_en && (freq_bad || wave_bad)) |=> err_reg)
        else $error("error flag not raised");
    a_noise_filter: assert property (@(posedge clk_sys) disable iff (rst)
        (clk_en && is_noise) |=> (!path_sel.elliptic_filter_on && path_sel.rc_filter_on))
        else $error("noise filter selection wrong");
    a_aux_forced_low: assert property (@(posedge clk_sys) disable iff (rst)
        (clk_en && aux_sel == wpm_pkg::WPM_SEL_LOW) |=> !path_sel.aux_comparator)
        else $error("forced low aux used comparator");
    a_sq_high: assert property (@(posedge clk_sys) disable iff (rst)
        (clk_en && square_source_select == wpm_pkg::WPM_SEL_HIGH)
        |=> path_sel.square_comparator)
        else $error("high square mode not comparator");
    a_hold_sweep: assert property (@(posedge clk_sys) disable iff (rst)
        (clk_en && hold_active && $past(clk_en) && $past(hold_active))
        |-> (held_high_reg == $past(held_high_reg)))
        else $error("held mode changed during sweep");
    a_sweep_toggle: assert property (@(posedge clk_sys) disable iff (rst)
        (clk_en && sweep_cmd) |=> (sweep_on_reg != $past(sweep_on_reg)))
        else $error("sweep did not toggle");
    a_rear_trig: assert property (@(posedge clk_sys) disable iff (rst)
        (clk_en && rear_output_function_select == wpm_pkg::WPM_REAR_TRIG)
        |=> (rear_marker_trigger_output == $past(trig_gen_in)))
        else $error("rear output not trigger generator");
    a_arb_aux: assert property (@(posedge clk_sys) disable iff (rst)
        (clk_en && aux_sel == wpm_pkg::WPM_SEL_AUTO && !is_sym(wave_reg))
        |=> !path_sel.aux_comparator)
        else $error("auto aux switched for ramp class");
endmodule
`default_nettype wire

// ### dv/wpm_analog_model.sv
`default_nettype none
module wpm_analog_model (
    // Clock and phase
    input  wire logic        clk_sys,
    input  wire logic [31:0] mem_address,
    // Analog side sources
    output logic             comparator_in,
    output logic             trig_gen_in,
    output logic             sweep_marker_in,
    output logic             hop_marker_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt_reg = 4'h0;

    // Free running pattern source, updated just after each edge
    always_ff @(posedge clk_sys)
    begin
        cnt_reg <= cnt_reg + 4'h1;
    end

    // Sources differ cycle by cycle so a wrong select cannot match by luck
    assign comparator_in   = ~mem_address[31];
    assign trig_gen_in     = cnt_reg[0];
    assign sweep_marker_in = cnt_reg[1];
    assign hop_marker_in   = cnt_reg[2] ^ cnt_reg[0];
endmodule
`default_nettype wire

// ### dv/testbench.sv
`default_nettype none
`include "wpm_regs.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic [31:0] mem_address;
    logic pready, pslverr, aux_out, square_out, rear_out, sweep_lamp;
    logic cmp_in, trig_in, sweep_in, hop_in;
    wpm_pkg::wpm_path_t path_sel;
    logic [32:0] qe[$];
    logic [32:0] qm[$];
    logic [32:0] me, mm;
    int miscompares = 0;
    int n_tests = 0;
    int wv, f, s, a, fl, hi, lo;
    logic src;

    // Clock
    always #5 clk_sys = ~clk_sys;

    wpm_mode_select #(.FLASH_CYCLES(4)) wpm_mode_select_i (.clk_sys(clk_sys), .rst(rst),
        .clk_en(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .comparator_in(cmp_in), .trig_gen_in(trig_in), .trig_gen_synced(1'b0),
        .sweep_marker_in(sweep_in), .hop_marker_in(hop_in),
        .symmetry_count(32'h8000_0000), .path_sel(path_sel), .aux_out(aux_out),
        .square_out(square_out), .rear_marker_trigger_output(rear_out),
        .sweep_lamp(sweep_lamp), .mem_address(mem_address));

    wpm_analog_model wpm_analog_model_i (.clk_sys(clk_sys), .mem_address(mem_address),
        .comparator_in(cmp_in), .trig_gen_in(trig_in), .sweep_marker_in(sweep_in),
        .hop_marker_in(hop_in));

    task test_done;
        $display("checks %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task chk_rd(input logic [32:0] got, input logic [32:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task chk_pin(input logic got, input logic exp);
        n_tests++;
        if (got !== exp)
        begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One APB transfer; a read leaves its expectation for the monitor
    task xfer(input logic w, input logic [11:0] ad, input logic [31:0] d,
              input logic [32:0] e, input logic [32:0] m);
        int n;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        if (!w)
        begin
            qe.push_back(e);
            qm.push_back(m);
        end
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20)
        begin
            miscompares++;
            test_done();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task wr(input logic [11:0] ad, input logic [31:0] d);
        xfer(1'b1, ad, d, 33'h0, 33'h0);
    endtask

    task rd(input logic [11:0] ad, input logic [31:0] e, input logic [31:0] m);
        xfer(1'b0, ad, 32'h0000_0000, {1'b0, e}, {1'b1, m});
    endtask

    // Expected path selects, as seen in status bits 6:3
    function automatic logic [31:0] pexp(input int w, input int fr, input int sq,
                                         input int ax, input int flt);
        logic hf, sqc, axc, el;
        hf = fr > `WPM_CHANGEOVER_HZ;
        sqc = sq == 2 || (sq == 0 && hf);
        axc = ax == 2 || (ax == 0 && hf && w <= 3);
        el = flt == 1 || (flt == 0 && (w <= 1 || (w inside {2, 3} && sqc)));
        return {25'h0, sqc, axc, el && w != 7, w == 7, 3'h0};
    endfunction

    // Read monitor: every completed read takes the oldest note
    always @(posedge clk_sys)
        if (psel && penable && pready && !pwrite)
        begin
            if (qe.size() == 0)
                miscompares++;
            me = qe.pop_front();
            mm = qm.pop_front();
            chk_rd({pslverr, prdata} & mm, me & mm);
        end

    // Hang guard
    initial
    begin
        #900us;
        miscompares++;
        test_done();
    end

    initial
    begin
        void'($urandom(32'hfc50_1096));
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        rd(`WPM_CTRL_ADDR, `WPM_CTRL_RESET, 32'hFFFF_FFFF);
        rd(`WPM_FREQ_ADDR, `WPM_FREQ_RESET, 32'hFFFF_FFFF);
        xfer(1'b0, 12'h020, 32'h0000_0000, 33'h1_0000_0000, 33'h1_0000_0000);
        // Random waveform, frequency and option mixes
        for (int i = 0; i < 40; i++)
        begin
            wv = $urandom % 8;
            s = $urandom % 4;
            f = s == 0 ? 30000 : s == 1 ? 30001 : s == 2 ? 1 + $urandom % 30000
                : 30001 + $urandom % 5000000;
            s = $urandom % 3;
            a = $urandom % 3;
            fl = $urandom % 3;
            wr(`WPM_CTRL_ADDR, 32'(fl * 16 + a * 4 + s));
            wr(`WPM_WAVE_ADDR, 32'(wv));
            wr(`WPM_FREQ_ADDR, 32'(f));
            rd(`WPM_STATUS_ADDR, pexp(wv, f, s, a, fl), {25'h0, wv inside {2, 3}, 6'h38});
        end
        // Held square mode while keying; settle below changeover before keying starts
        wr(`WPM_FREQ_ADDR, 32'd1000);
        wr(`WPM_CTRL_ADDR, 32'h0000_0200);
        wr(`WPM_WAVE_ADDR, 32'h0000_0002);
        wr(`WPM_FREQ_ADDR, 32'd50000);
        rd(`WPM_STATUS_ADDR, 32'h0000_0000, 32'h0000_0040);
        wr(`WPM_CTRL_ADDR, 32'h0000_0000);
        rd(`WPM_STATUS_ADDR, 32'h0000_0040, 32'h0000_0040);
        wr(`WPM_CTRL_ADDR, 32'h0000_0200);
        wr(`WPM_FREQ_ADDR, 32'd1000);
        rd(`WPM_STATUS_ADDR, 32'h0000_0040, 32'h0000_0040);
        // Frequency stop on: boundary, refused entry, refused selection
        wr(`WPM_CTRL_ADDR, 32'h0000_0040);
        wr(`WPM_WAVE_ADDR, 32'h0000_0001);
        wr(`WPM_FREQ_ADDR, `WPM_WAVEFORM_FREQ_LIMIT_ENABLE_HZ);
        wr(`WPM_FREQ_ADDR, `WPM_WAVEFORM_FREQ_LIMIT_ENABLE_HZ + 32'h1);
        rd(`WPM_FREQ_ADDR, `WPM_WAVEFORM_FREQ_LIMIT_ENABLE_HZ, 32'hFFFF_FFFF);
        rd(`WPM_STATUS_ADDR, 32'h0000_0001, 32'h0000_0001);
        for (int w = 1; w < 7; w++)
        begin
            wr(`WPM_ERRCLR_ADDR, 32'h0000_0001);
            wr(`WPM_WAVE_ADDR, 32'h0000_0000);
            wr(`WPM_FREQ_ADDR, 32'd200000);
            wr(`WPM_WAVE_ADDR, 32'(w));
            rd(`WPM_WAVE_ADDR, w inside {2, 3} ? w : 0, 32'h0000_0007);
            rd(`WPM_STATUS_ADDR, w inside {2, 3} ? 0 : 1, 32'h0000_0001);
        end
        wr(`WPM_CTRL_ADDR, 32'h0000_0000);
        wr(`WPM_WAVE_ADDR, 32'h0000_0006);
        rd(`WPM_WAVE_ADDR, 32'h0000_0006, 32'h0000_0007);
        // Rear output source and sweep lamp: ctrl, source, lamp per step
        for (int k = 0; k < 7; k++)
        begin
            a = k == 0 ? 32'h800 : k == 1 ? 32'h100 : k == 2 ? 32'h800 : k == 3 ? 32'h400
                : k == 4 ? 32'h480 : k == 5 ? 32'h880 : 32'h800;
            s = (k == 0 || k == 5) ? 0 : (k == 3 || k == 4) ? 1 : 2;
            hi = (k <= 1 || k == 5) ? 1 : 0;
            wr(`WPM_CTRL_ADDR, 32'(a));
            rd(`WPM_STATUS_ADDR, 32'(hi * 256), 32'h0000_0100);
            chk_pin(sweep_lamp, hi[0]);
            repeat (8)
            begin
                @(posedge clk_sys);
                src = s == 0 ? sweep_in : s == 1 ? hop_in : trig_in;
                #1;
                chk_pin(rear_out, src);
            end
        end
        // Edit mode flashes the lamp with sweep off
        wr(`WPM_CTRL_ADDR, 32'h0000_1000);
        hi = 0;
        lo = 0;
        repeat (20)
        begin
            @(posedge clk_sys);
            if (sweep_lamp === 1'b1) hi++;
            if (sweep_lamp === 1'b0) lo++;
        end
        chk_pin(hi > 0 && lo > 0, 1'b1);
        // Both squares digital: zero phase aligns them, half a cycle inverts aux
        wr(`WPM_CTRL_ADDR, 32'h0000_0005);
        wr(`WPM_PHASE_ADDR, 32'h0000_0000);
        wr(`WPM_FREQ_ADDR, 32'h1000_0000);
        repeat (16)
        begin
            @(posedge clk_sys);
            #1;
            chk_pin(aux_out, square_out);
        end
        wr(`WPM_PHASE_ADDR, 32'h8000_0000);
        repeat (16)
        begin
            @(posedge clk_sys);
            #1;
            chk_pin(aux_out, !square_out);
        end
        repeat (4) @(posedge clk_sys);
        if (qe.size() != 0)
            miscompares++;
        test_done();
    end
endmodule
`default_nettype wire
